/* src/pinmux_defs.svh */
// offsets, field positions, reset values and widths of the pin mux block
`ifndef PINMUX_DEFS_SVH
`define PINMUX_DEFS_SVH

// register byte offsets on the apb bus
`define OFF_P8_DIR    8'h00
`define OFF_P8_DATA   8'h04
`define OFF_P9_DIR    8'h08
`define OFF_P9_DATA   8'h0c
`define OFF_PIN_CTL   8'h10
`define OFF_PIN_STAT  8'h14

// widths of the port slices handled here
`define P8_W          6
`define P9_W          8
`define CTL_W         14
`define PIN_N         14

// control register field positions
`define CTL_SPS       0
`define CTL_RXE       1
`define CTL_TXE       2
`define CTL_INT4      3
`define CTL_INT3      4
`define CTL_HL_LSB    5
`define CTL_HL_MSB    7
`define CTL_FGA       8
`define CTL_PMEV      9
`define CTL_I2C_ON    10
`define CTL_IAS       11
`define CTL_IBS       12
`define CTL_SUBCLK    13

// port 9 special bit positions
`define P9_PHI_BIT    6
`define P9_SDA_BIT    7

// reset values
`define P8_DIR_RST    6'h00
`define P8_OUT_RST    6'h00
`define P9_DIR_RST    8'h00
`define P9_OUT_RST    8'h00
`define CTL_RST       14'h0000

// stages of the pin input synchroniser
`define SYNC_STAGES   3

`endif

/* src/pinmux_pkg.sv */
// types shared by the pin mux block
package pinmux_pkg;

    // function now held by the sda pin, one-hot
    typedef enum logic [2:0] {
        FN97_GPIN  = 3'b001,
        FN97_GPOUT = 3'b010,
        FN97_SDA   = 3'b100
    } pin97_fn_t;

    // whole registered state of the mux
    typedef struct packed {
        logic [5:0]  p8_dir;     // port 8 direction, pins 80..85
        logic [5:0]  p8_out;     // port 8 output latch
        logic [7:0]  p9_dir;     // port9_direction
        logic [7:0]  p9_out;     // port9_output_latch
        logic [13:0] ctl;        // function enables
        logic [31:0] rdata;      // apb read data
        logic [5:0]  p8_o;       // pad levels, port 8
        logic [5:0]  p8_oe;      // pad enables, port 8
        logic [7:0]  p9_o;       // pad levels, port 9
        logic [7:0]  p9_oe;      // pad enables, port 9
        logic        phi_on;     // pin 96 carries the system clock
        logic        rx_q;       // serial receive level
        logic        int4_q;     // interrupt 4 level
        logic        int3_q;     // interrupt 3 level
        logic        pd_q;       // host link power-down level
        logic        ckrun_q;    // clock-run level
        logic        a20_q;      // gate-a20 level
        logic        pmev_q;     // power event level
        logic        sda_q;      // i2c data level
        logic        subclk_q;   // external subclock level
    } state_t;

endpackage

/* src/pin_sync.sv */
// three-stage synchroniser with agreement filter for pad inputs
`timescale 1ns/1ns
module pin_sync #(
    parameter int W = 8
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         ce,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    // all stages kept together
    typedef struct packed {
        logic [W-1:0] s1;   // metastable stage, read only by s2
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } sync_t;

    sync_t sync_reg;
    sync_t sync_next;

    // a change counts only when stages two and three agree
    always_comb begin
        sync_next = sync_reg;
        if (ce) begin
            sync_next.s1 = d;
            sync_next.s2 = sync_reg.s1;
            sync_next.s3 = sync_reg.s2;
            for (int i = 0; i < W; i++) begin
                if (sync_reg.s2[i] == sync_reg.s3[i]) begin
                    sync_next.q[i] = sync_reg.s3[i];
                end
            end
        end
    end

    // state register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync_reg <= '0;
        end else begin
            sync_reg <= sync_next;
        end
    end

    assign q = sync_reg.q;
endmodule

/* src/io_select.sv */
// per-pin choice between a peripheral function and general i/o
`timescale 1ns/1ns
module io_select (
    input  wire logic take,
    input  wire logic func_o,
    input  wire logic func_oe,
    input  wire logic dir,
    input  wire logic latch,
    output logic      o,
    output logic      oe
);
    // peripheral wins when it takes the pin, else direction bit rules
    always_comb begin
        if (take) begin
            o  = func_o;
            oe = func_oe;
        end else begin
            o  = latch;
            oe = dir;
        end
    end
endmodule

/* src/port8_9_pin_function_mux.sv */
// pin function mux for pins 80..85 and port 9, with apb registers
//
// Design decisions made here: the APB interface to the registers and the address map.
`include "pinmux_defs.svh"
`timescale 1ns/1ns
module port8_9_pin_function_mux
    import pinmux_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        ce,
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [5:0]  pad8_i,
    output logic      [5:0]  pad8_o,
    output logic      [5:0]  pad8_oe,
    input  wire logic [7:0]  pad9_i,
    output logic      [7:0]  pad9_o,
    output logic      [7:0]  pad9_oe,
    input  wire logic        serial_tx_out_1,
    output logic             serial_rx_in_1,
    output logic             ext_int4_input,
    output logic             ext_int3_input,
    output logic             host_link_powerdown_in,
    input  wire logic        ckrun_drive_o,
    input  wire logic        ckrun_drive_oe,
    output logic             host_clock_run_line,
    input  wire logic        a20_drive_o,
    output logic             gate_a20_line,
    input  wire logic        pm_event_drive_o,
    output logic             power_mgmt_event_line,
    input  wire logic        sda_drive_low,
    output logic             i2c0_data_line,
    output logic             ext_subclock_in,
    input  wire logic        sys_clk_phi
);
    state_t            state_reg;    // registered state
    state_t            state_next;   // its next value
    logic [5:0]        sync8;        // filtered port 8 pad levels
    logic [7:0]        sync9;        // filtered port 9 pad levels
    logic [31:0]       rd_word;      // read data chosen in setup
    logic              addr_hit;     // address maps to a register
    pin97_fn_t         fn97;         // present sda pin function
    logic [`PIN_N-1:0] take_v;       // peripheral owns pin
    logic [`PIN_N-1:0] fo_v;         // peripheral pad level
    logic [`PIN_N-1:0] foe_v;        // peripheral pad enable
    logic [`PIN_N-1:0] dir_v;        // direction bits, all pins
    logic [`PIN_N-1:0] lat_v;        // output latches, all pins
    logic [`PIN_N-1:0] sel_o;        // chosen pad level
    logic [`PIN_N-1:0] sel_oe;       // chosen pad enable

    // decoded control bits
    logic       serial_pin_route_sel;
    logic       rx_on_ctl;
    logic       tx_on_ctl;
    logic       ext_int4_allow;
    logic       ext_int3_allow;
    logic [2:0] host_link_ch_enables;
    logic       fast_gate_a20_en;
    logic       pm_event_out_en;
    logic       i2c_unit_on;
    logic       i2c0_route_a_sel;
    logic       i2c0_route_b_sel;
    logic       ext_subclk_in_en;
    logic       rx_take;      // serial owns receive pin
    logic       tx_take;      // serial owns transmit pin
    logic       hl_any;       // any host link channel on
    logic       sda_pin_take; // i2c owns pin 97
    logic       subclk_take;  // subclock input on pin 96
    logic       pin96_dir;    // direction of the clock pin

    // field split of the control register
    assign serial_pin_route_sel = state_reg.ctl[`CTL_SPS];
    assign rx_on_ctl            = state_reg.ctl[`CTL_RXE];
    assign tx_on_ctl            = state_reg.ctl[`CTL_TXE];
    assign ext_int4_allow       = state_reg.ctl[`CTL_INT4];
    assign ext_int3_allow       = state_reg.ctl[`CTL_INT3];
    assign host_link_ch_enables = state_reg.ctl[`CTL_HL_MSB:`CTL_HL_LSB];
    assign fast_gate_a20_en     = state_reg.ctl[`CTL_FGA];
    assign pm_event_out_en      = state_reg.ctl[`CTL_PMEV];
    assign i2c_unit_on          = state_reg.ctl[`CTL_I2C_ON];
    assign i2c0_route_a_sel     = state_reg.ctl[`CTL_IAS];
    assign i2c0_route_b_sel     = state_reg.ctl[`CTL_IBS];
    assign ext_subclk_in_en     = state_reg.ctl[`CTL_SUBCLK];
    assign pin96_dir            = state_reg.p9_dir[`P9_PHI_BIT];

    // pin ownership terms
    assign rx_take = !serial_pin_route_sel && rx_on_ctl;
    assign tx_take = !serial_pin_route_sel && tx_on_ctl;
    assign hl_any  = |host_link_ch_enables;
    assign sda_pin_take = i2c_unit_on &&
        !(i2c0_route_a_sel || i2c0_route_b_sel);
    assign subclk_take = ext_subclk_in_en && !pin96_dir;

    // pad inputs come from outside the clock domain
    pin_sync #(.W(`P8_W)) u_sync8 (
        .clk (clk),
        .rst (rst),
        .ce  (ce),
        .d   (pad8_i),
        .q   (sync8)
    );

    pin_sync #(.W(`P9_W)) u_sync9 (
        .clk (clk),
        .rst (rst),
        .ce  (ce),
        .d   (pad9_i),
        .q   (sync9)
    );

    // per-pin peripheral requests; index 0..5 pins 80..85, 6..13 port 9
    always_comb begin
        take_v = '0;
        fo_v   = '0;
        foe_v  = '0;
        take_v[0] = pm_event_out_en;
        fo_v[0]   = pm_event_drive_o;
        foe_v[0]  = 1'b1;
        take_v[1] = fast_gate_a20_en;
        fo_v[1]   = a20_drive_o;
        foe_v[1]  = 1'b1;
        take_v[2] = hl_any;
        fo_v[2]   = ckrun_drive_o;
        foe_v[2]  = ckrun_drive_oe;
        take_v[4] = tx_take;
        fo_v[4]   = serial_tx_out_1;
        foe_v[4]  = 1'b1;
        take_v[5] = rx_take;
        // subclock input holds the pin as input whatever the direction
        take_v[6 + `P9_PHI_BIT] = ext_subclk_in_en;
        // open drain: only ever pull low
        take_v[6 + `P9_SDA_BIT] = sda_pin_take;
        foe_v[6 + `P9_SDA_BIT]  = sda_drive_low;
    end

    assign dir_v = {state_reg.p9_dir, state_reg.p8_dir};
    assign lat_v = {state_reg.p9_out, state_reg.p8_out};

    // one selector per pin, plain gpio where nothing takes it
    generate
        for (genvar g = 0; g < `PIN_N; g++) begin : g_pin
            io_select u_sel (
                .take    (take_v[g]),
                .func_o  (fo_v[g]),
                .func_oe (foe_v[g]),
                .dir     (dir_v[g]),
                .latch   (lat_v[g]),
                .o       (sel_o[g]),
                .oe      (sel_oe[g])
            );
        end
    endgenerate

    // sda pin function for the status register
    always_comb begin
        if (sda_pin_take) begin
            fn97 = FN97_SDA;
        end else if (state_reg.p9_dir[`P9_SDA_BIT]) begin
            fn97 = FN97_GPOUT;
        end else begin
            fn97 = FN97_GPIN;
        end
    end

    // read data decode
    always_comb begin
        rd_word  = 32'h0000_0000;
        addr_hit = 1'b1;
        if (paddr == `OFF_P8_DIR) begin
            rd_word = 32'h0000_0000; // write-only, reads zero
        end else if (paddr == `OFF_P8_DATA) begin
            for (int i = 0; i < `P8_W; i++) begin
                rd_word[i] = state_reg.p8_dir[i] ?
                    state_reg.p8_out[i] : sync8[i];
            end
        end else if (paddr == `OFF_P9_DIR) begin
            rd_word = 32'h0000_0000; // write-only, reads zero
        end else if (paddr == `OFF_P9_DATA) begin
            for (int i = 0; i < `P9_W; i++) begin
                rd_word[i] = state_reg.p9_dir[i] ?
                    state_reg.p9_out[i] : sync9[i];
            end
            rd_word[`P9_PHI_BIT] = sync9[`P9_PHI_BIT];
        end else if (paddr == `OFF_PIN_CTL) begin
            rd_word[`CTL_W-1:0] = state_reg.ctl;
        end else if (paddr == `OFF_PIN_STAT) begin
            rd_word[2:0] = fn97;
            rd_word[3]   = rx_take;
            rd_word[4]   = tx_take;
            rd_word[5]   = hl_any;
            rd_word[6]   = subclk_take;
            rd_word[7]   = state_reg.phi_on;
        end else begin
            addr_hit = 1'b0; // unmapped, error answer
        end
    end

    // next state: register writes, read capture, pad and level update
    always_comb begin
        state_next = state_reg;
        if (ce) begin
            // writes land at the access edge only
            if (psel && penable && pwrite) begin
                if (paddr == `OFF_P8_DIR) begin
                    state_next.p8_dir = pwdata[`P8_W-1:0];
                end else if (paddr == `OFF_P8_DATA) begin
                    state_next.p8_out = pwdata[`P8_W-1:0];
                end else if (paddr == `OFF_P9_DIR) begin
                    state_next.p9_dir = pwdata[`P9_W-1:0];
                end else if (paddr == `OFF_P9_DATA) begin
                    // bit 6 latch is never read back, so it is harmless
                    state_next.p9_out = pwdata[`P9_W-1:0];
                end else if (paddr == `OFF_PIN_CTL) begin
                    state_next.ctl = pwdata[`CTL_W-1:0];
                end
            end
            // read data captured in setup so it comes from a flop
            if (psel && !penable) begin
                state_next.rdata = rd_word;
            end
            // pad drive registered: one clean step per change
            state_next.p8_o  = sel_o[5:0];
            state_next.p8_oe = sel_oe[5:0];
            state_next.p9_o  = sel_o[13:6];
            state_next.p9_oe = sel_oe[13:6];
            state_next.phi_on = pin96_dir && !ext_subclk_in_en;
            // levels handed to peripherals, idle high when not routed, subclock idle low; a20 and power event always follow their pins
            state_next.rx_q   = rx_take ? sync8[5] : 1'b1;
            state_next.int4_q = ext_int4_allow ? sync8[5] : 1'b1;
            state_next.int3_q = ext_int3_allow ? sync8[4] : 1'b1;
            state_next.pd_q   = hl_any ? sync8[3] : 1'b1;
            state_next.ckrun_q = hl_any ? sync8[2] : 1'b1;
            state_next.a20_q  = sync8[1];
            state_next.pmev_q = sync8[0];
            state_next.sda_q  = sda_pin_take ?
                sync9[`P9_SDA_BIT] : 1'b1;
            state_next.subclk_q = subclk_take ?
                sync9[`P9_PHI_BIT] : 1'b0;
        end
    end

    // state register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg        <= '0;
            state_reg.p8_dir <= `P8_DIR_RST;
            state_reg.p8_out <= `P8_OUT_RST;
            state_reg.p9_dir <= `P9_DIR_RST;
            state_reg.p9_out <= `P9_OUT_RST;
            state_reg.ctl    <= `CTL_RST;
            state_reg.rx_q   <= 1'b1;
            state_reg.int4_q <= 1'b1;
            state_reg.int3_q <= 1'b1;
            state_reg.pd_q   <= 1'b1;
            state_reg.ckrun_q <= 1'b1;
            state_reg.sda_q  <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

    // bus answer: zero wait, frozen while the clock enable is low
    assign pready  = ce;
    assign pslverr = psel && penable && !addr_hit;
    assign prdata  = state_reg.rdata;

    // pads; the clock is gated in, not re-registered, to stay a clock
    assign pad8_o  = state_reg.p8_o;
    assign pad8_oe = state_reg.p8_oe;
    assign pad9_o  = {state_reg.p9_o[7],
                      state_reg.phi_on ? sys_clk_phi : state_reg.p9_o[6],
                      state_reg.p9_o[5:0]};
    assign pad9_oe = state_reg.p9_oe;

    // peripheral-side levels
    assign serial_rx_in_1         = state_reg.rx_q;
    assign ext_int4_input         = state_reg.int4_q;
    assign ext_int3_input         = state_reg.int3_q;
    assign host_link_powerdown_in = state_reg.pd_q;
    assign host_clock_run_line    = state_reg.ckrun_q;
    assign gate_a20_line          = state_reg.a20_q;
    assign power_mgmt_event_line  = state_reg.pmev_q;
    assign i2c0_data_line         = state_reg.sda_q;
    assign ext_subclock_in        = state_reg.subclk_q;

    // checks on the mux, sampled on the rising edge of clk
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence rd_p9_setup;
        ce && psel && !penable && !pwrite && paddr == `OFF_P9_DATA;
    endsequence
    sequence rd_p9_access;
        psel && penable;
    endsequence

    a_rx_pin_take: assert property (
        ce && rx_take |=> !pad8_oe[5] && serial_rx_in_1 == $past(sync8[5]))
        else $error("receive pin not held as serial input");
    a_rx_gpio_dir: assert property (
        ce && !rx_take |=> pad8_oe[5] == $past(state_reg.p8_dir[5]))
        else $error("receive pin direction not followed");
    a_int4_level: assert property (
        ce && ext_int4_allow |=> ext_int4_input == $past(sync8[5]))
        else $error("interrupt 4 not fed from receive pin");
    a_tx_pin_drive: assert property (
        ce && tx_take |=> pad8_oe[4] && pad8_o[4] == $past(serial_tx_out_1))
        else $error("transmit pin not driving serial data");
    a_int3_level: assert property (
        ce && ext_int3_allow |=> ext_int3_input == $past(sync8[4]))
        else $error("interrupt 3 not fed from transmit pin");
    a_pd_level: assert property (
        ce && hl_any |=> host_link_powerdown_in == $past(sync8[3]) &&
            pad8_oe[3] == $past(state_reg.p8_dir[3]))
        else $error("pin 83 power-down routing wrong");
    a_ckrun_own: assert property (
        ce && hl_any |=> pad8_oe[2] == $past(ckrun_drive_oe))
        else $error("clock-run enable not handed to host link");
    a_a20_drive: assert property (
        ce && fast_gate_a20_en |=> pad8_oe[1] &&
            pad8_o[1] == $past(a20_drive_o))
        else $error("gate-a20 pin not driven");
    a_pmev_drive: assert property (
        ce && pm_event_out_en |=> pad8_oe[0] &&
            pad8_o[0] == $past(pm_event_drive_o))
        else $error("power event pin not driven");
    a_p9_gpio_dir: assert property (
        ce |=> pad9_oe[5:0] == $past(state_reg.p9_dir[5:0]))
        else $error("port 9 general pins ignore direction");
    a_p9_read_back: assert property (
        rd_p9_setup ##1 rd_p9_access |-> prdata[5] ==
            ($past(state_reg.p9_dir[5]) ? $past(state_reg.p9_out[5])
                                        : $past(sync9[5])))
        else $error("port 9 read does not follow direction");
    a_p96_read_pin: assert property (
        rd_p9_setup |=> prdata[6] == $past(sync9[6]))
        else $error("bit 6 read is not the pin level");
    a_sda_take: assert property (
        ce && sda_pin_take |=> !pad9_o[7] &&
            pad9_oe[7] == $past(sda_drive_low))
        else $error("sda pin not open drain under i2c");
    a_phi_output: assert property (
        ce && pin96_dir && !ext_subclk_in_en |=> pad9_oe[6] &&
            state_reg.phi_on)
        else $error("pin 96 not giving the system clock");
    a_subclk_input: assert property (
        ce && ext_subclk_in_en |=> !pad9_oe[6] && !state_reg.phi_on)
        else $error("subclock pin still driven");
    a_dir_reset: assert property (
        $fell(rst) |-> state_reg.p9_dir == 8'h00 && pad9_oe == 8'h00)
        else $error("port 9 direction not cleared by reset");
endmodule

/* bench/pad_board.sv */
// board side of the shared pads: resolves each pad seen by the device
`timescale 1ns/1ns
module pad_board (
    input  wire logic [5:0] pad8_o,
    input  wire logic [5:0] pad8_oe,
    input  wire logic [7:0] pad9_o,
    input  wire logic [7:0] pad9_oe,
    input  wire logic [5:0] board8,
    input  wire logic [7:0] board9,
    output logic      [5:0] pad8_i,
    output logic      [7:0] pad9_i
);
    // a driven pad shows the device level, an undriven one the board level;
    // the board always holds a firm level, so nothing floats
    assign pad8_i = (pad8_oe & pad8_o) | (~pad8_oe & board8);
    assign pad9_i = (pad9_oe & pad9_o) | (~pad9_oe & board9);
endmodule

/* bench/tb_port8_9_pin_function_mux.sv */
// self-checking bench for the port 8/9 pin function mux
`include "pinmux_defs.svh"
`timescale 1ns/1ns
module tb_port8_9_pin_function_mux;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic        pready, pslverr, err;
    logic [5:0]  p8o, p8oe, p8i;
    logic [7:0]  p9o, p9oe, p9i;
    logic [5:0]  b8 = 6'h2a;       // board levels, pins 85..80
    logic [7:0]  b9 = 8'h5a;       // board levels, pins 97..90
    logic [6:0]  drv = 7'h00;      // tx, ckrun o/oe, a20, pmev, sda, phi
    logic [8:0]  obs;              // rx,int4,int3,pd,ckrun,a20,pmev,sda,subclk
    int          miscompares = 0;
    int          n_compared = 0;

    port8_9_pin_function_mux uut (.clk(clk), .rst(rst), .ce(1'b1),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pad8_i(p8i), .pad8_o(p8o), .pad8_oe(p8oe),
        .pad9_i(p9i), .pad9_o(p9o), .pad9_oe(p9oe),
        .serial_tx_out_1(drv[6]), .serial_rx_in_1(obs[8]),
        .ext_int4_input(obs[7]), .ext_int3_input(obs[6]),
        .host_link_powerdown_in(obs[5]), .ckrun_drive_o(drv[5]),
        .ckrun_drive_oe(drv[4]), .host_clock_run_line(obs[4]),
        .a20_drive_o(drv[3]), .gate_a20_line(obs[3]),
        .pm_event_drive_o(drv[2]), .power_mgmt_event_line(obs[2]),
        .sda_drive_low(drv[1]), .i2c0_data_line(obs[1]),
        .ext_subclock_in(obs[0]), .sys_clk_phi(drv[0]));
    pad_board board (.pad8_o(p8o), .pad8_oe(p8oe), .pad9_o(p9o),
        .pad9_oe(p9oe), .board8(b8), .board9(b9), .pad8_i(p8i),
        .pad9_i(p9i));

    // free-running 100 MHz clock
    initial forever #5 clk = ~clk;

    // verdict and end of run, reached from the end or from a timeout
    task automatic conclude;
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // one compare, counted; unknowns never match
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    // one apb transfer, held until pready is sampled high at an edge
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            miscompares++;
            conclude();
        end
    endtask

    // pad inputs cross a three-flop synchroniser, filter and output flop
    task automatic settle;
        repeat (8) @(posedge clk);
    endtask

    // pads, peripheral inputs and port 9 reads straight out of reset
    task automatic t_reset;
        chk("oe", 14'h0, {p8oe, p9oe});
        chk("ins", 9'h1fa, obs);
        apb(1'b0, `OFF_P9_DATA, 32'h0);
        chk("p9 read", 32'h5a, rd);
        apb(1'b0, `OFF_P9_DIR, 32'h0);
        chk("p9 dir read", 32'h0, rd);
        $display("reset test done");
    endtask

    // port 9 general i/o, latch versus pin on read
    task automatic t_port9;
        apb(1'b1, `OFF_P9_DIR, 32'hbf);
        apb(1'b1, `OFF_P9_DATA, 32'h83);
        settle();
        chk("p9 oe", 8'hbf, p9oe);
        chk("p9 o", 8'h83, p9o & p9oe);
        apb(1'b0, `OFF_P9_DATA, 32'h0);
        chk("p9 read out", 32'hc3, rd);
        apb(1'b1, `OFF_P9_DIR, 32'h00);
        settle();
        apb(1'b0, `OFF_P9_DATA, 32'h0);
        chk("p9 read in", 32'h5a, rd);
        $display("port 9 test done");
    endtask

    // pin 96 as clock output, then as subclock input
    task automatic t_pin96;
        drv[0] <= 1'b1;
        apb(1'b1, `OFF_P9_DIR, 32'h40);
        settle();
        chk("clk out", 2'b11, {p9oe[6], p9o[6]});
        drv[0] <= 1'b0;
        @(posedge clk);
        @(negedge clk);
        chk("clk low", 1'b0, p9o[6]);
        apb(1'b1, `OFF_P9_DIR, 32'h00);
        apb(1'b1, `OFF_PIN_CTL, 32'h2000);
        settle();
        chk("subclk hi", 2'b01, {p9oe[6], obs[0]});
        b9 <= 8'h9a;
        settle();
        chk("subclk lo", 1'b0, obs[0]);
        apb(1'b0, `OFF_P9_DATA, 32'h0);
        chk("bit6 pin", 32'h9a, rd);
        $display("pin 96 test done");
    endtask

    // i2c take from unit enable and both route selects
    task automatic t_sda;
        drv[1] <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, `OFF_PIN_CTL, 32'h400 | (i << 11));
            settle();
            chk("sda oe", i == 0, p9oe[7]);
            chk("sda line", i != 0, obs[1]);
        end
        drv[1] <= 1'b0;
        $display("i2c test done");
    endtask

    // serial pins over direction, and the interrupt taps beside them
    task automatic t_serial;
        apb(1'b1, `OFF_P8_DIR, 32'h30);
        apb(1'b1, `OFF_P8_DATA, 32'h00);
        drv[6] <= 1'b1;
        apb(1'b1, `OFF_PIN_CTL, 32'h1e);
        settle();
        chk("ser oe", 2'b01, p8oe[5:4]);
        chk("tx o", 1'b1, p8o[4]);
        chk("rx int", 3'b111, obs[8:6]);
        drv[6] <= 1'b0;
        settle();
        chk("int3 lo", 3'b110, obs[8:6]);
        apb(1'b1, `OFF_PIN_CTL, 32'h1f);
        settle();
        chk("gp oe", 4'b1100, {p8oe[5:4], p8o[5:4]});
        chk("gp int", 3'b100, obs[8:6]);
        $display("serial test done");
    endtask

    // host link pins 83..80 with functions on, then as general i/o
    task automatic t_host;
        apb(1'b1, `OFF_P8_DIR, 32'h00);
        drv[5:2] <= 4'b0110;
        apb(1'b1, `OFF_PIN_CTL, 32'h380);
        settle();
        chk("hl oe", 4'b0111, p8oe[3:0]);
        chk("hl o", 3'b010, p8o[2:0] & p8oe[2:0]);
        chk("hl in", 4'b1010, obs[5:2]);
        apb(1'b1, `OFF_PIN_CTL, 32'h0);
        apb(1'b1, `OFF_P8_DIR, 32'h0f);
        apb(1'b1, `OFF_P8_DATA, 32'h05);
        settle();
        chk("gp oe", 8'hf5, {p8oe[3:0], p8o[3:0]});
        // pin 80 now drives its latch 1, which the event input still sees
        chk("gp in", 4'b1101, obs[5:2]);
        apb(1'b0, 8'h18, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, err});
        chk("unmapped rd", 32'h0, rd);
        $display("host link test done");
    endtask

    // reset, then every scenario in turn
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        settle();
        t_reset();
        t_port9();
        t_pin96();
        t_sda();
        t_serial();
        t_host();
        conclude();
    end
endmodule
